// ==== pkg/uart_rx_consts.svh ====
// Register offsets, field positions, reset values and bit-timing counts.
`ifndef UART_RX_CONSTS_SVH
`define UART_RX_CONSTS_SVH
`define OFS_CTRL    4'h0
`define OFS_STATUS  4'h4
`define OFS_DATA    4'h8
`define OFS_BAUD    4'hC
`define CB_RECEIVER_ENABLE     0
`define CB_NINE     1
`define CB_PEN      2
`define CB_PTYPE    3
`define CB_TWOSTOP  4
`define CB_BRK      5
`define CB_RIE      6
`define SB_READY    0
`define SB_OVR      1
`define SB_NOISE    2
`define SB_FRAMING_ERROR_FLAG     3
`define SB_PARITY_ERROR_FLAG     4
`define SB_IDLE     5
`define CTRL_RST    7'h00
`define BAUD_RST    8'h00
`define OS_LAST     4'hF
`define SMP_A       4'h7
`define SMP_B       4'h8
`define SMP_C       4'h9
`define BRK_BITS    4'hD
`endif

// ==== pkg/uart_rx_pkg.sv ====
// Types shared by the serial receive and break logic.
package uart_rx_pkg;
  typedef logic [31:0] word_t;
  typedef enum logic [2:0] {
    R_IDLE  = 3'b000,
    R_START = 3'b001,
    R_DATA  = 3'b010,
    R_STOP  = 3'b011,
    R_WAIT  = 3'b100
  } rx_state_t;
  typedef enum logic [1:0] {
    T_IDLE = 2'b00,
    T_BRK  = 2'b01,
    T_STOP = 2'b10
  } tx_state_t;
endpackage : uart_rx_pkg

// ==== hw/rx_fifo.sv ====
// Small shift-queue holding received words with their status bits.
`timescale 1ns/1ps
module rx_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 2
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             flush_i,
  input  wire logic             push_i,
  input  wire logic [WIDTH-1:0] push_data_i,
  input  wire logic             pop_i,
  output logic                  full_o,
  output logic                  empty_o,
  output logic [WIDTH-1:0]      head_o
);
  logic [WIDTH-1:0]     ent [DEPTH];
  logic [DEPTH-1:0]     vld;
  logic                 do_pop;
  logic                 do_push;

  // The head is entry zero, so read data always come out of a flip-flop.
  assign do_pop  = pop_i & vld[0];
  assign do_push = push_i & (~vld[DEPTH-1] | do_pop);
  assign full_o  = vld[DEPTH-1];
  assign empty_o = ~vld[0];
  assign head_o  = ent[0];

  // Each entry either shifts down on a pop or takes the pushed word.
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    logic nv_up;
    logic pv_dn;
    logic tk_here;
    if (i == DEPTH - 1) begin : g_top
      assign nv_up = 1'b0;
    end else begin : g_mid
      assign nv_up = vld[i+1];
    end
    // The bottom entry has no neighbour below, so it counts as occupied.
    if (i == 0) begin : g_bot
      assign pv_dn = 1'b1;
    end else begin : g_upr
      assign pv_dn = vld[i-1];
    end
    assign tk_here = do_push & (do_pop ? (vld[i] & ~nv_up) : (~vld[i] & pv_dn));
    always_ff @(posedge clk_i) begin
      if (rst_i || flush_i) begin
        vld[i] <= 1'b0;
      end else if (do_pop) begin
        vld[i] <= nv_up | tk_here;
      end else begin
        vld[i] <= vld[i] | tk_here;
      end
    end
    // Reset clears stored flags; a pop does not clear entries, so the head of an empty queue holds a stale word.
    always_ff @(posedge clk_i) begin
      if (rst_i || flush_i) begin
        ent[i] <= '0;
      end else if (tk_here) begin
        ent[i] <= push_data_i;
      end else if (do_pop && i != DEPTH - 1) begin
        ent[i] <= ent[(i + 1) % DEPTH];
      end
    end
  end

  // A push into a queue with room leaves it non-empty next cycle.
  push_lands_a: assert property (@(posedge clk_i) disable iff (rst_i)
    push_i && !full_o && !flush_i |=> !empty_o)
    else $error("pushed word not held");
endmodule : rx_fifo

// ==== hw/uart_rx_break.sv ====
// Serial receiver with two-word buffer, break sender and Wishbone register slave.
//
// Summary of operation
// - Break starts at next transmission once request held over divisor+1 clocks.
// - Break is a start bit plus 13 times N zero bits, then stop.
// - Breaks repeat while requested; after clearing, finish then send stop bits.
// - Sending break never raises a transmit-empty interrupt.
// - Word length 8 or 9 bits; ninth bit read as bit 8 of the data register.
// - Recovery runs at sixteen ticks per bit; shifter once per bit.
// - Each bit level is a majority of three samples.
// - Bits shift in least significant first.
// - After stop sample, word moves to buffer if room; enable starts search.
// - Buffer holds two words while a third shifts in; read in time.
// - Overrun sets flag, keeps buffer, drops word, requests interrupt if enabled.
// - Ready flag while buffer holds data; transfer requests interrupt if enabled.
// - Ready, overrun, noise clear by status read then data read, or by disabling the receiver.
// - Break ends after word plus one stop; sets ready, framing, idle; zeros.
// - After break wait for high line before seeking a start bit.
// - Idle flag low from start detection to stop bit, else high.
// - Noise flag rises with ready, data kept, no own interrupt.
// - Framing error when stop bit samples zero.
// - Parity error when enabled parity of word mismatches selected type.
// - Framing and parity flags reset-cleared, stored with the word.
// - Parity type selects odd or even; receiver checks one stop bit.
`timescale 1ns/1ps
`include "uart_rx_consts.svh"
module uart_rx_break (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [3:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire uart_rx_pkg::word_t wb_dat_i,
  output uart_rx_pkg::word_t      wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic               rx_i,
  output logic                    tx_o,
  output logic                    rx_int_req_o
);
  import uart_rx_pkg::*;

  logic [6:0]  serial_control_one;
  logic [7:0]  baud_divisor, div_cnt;
  logic        s1, s2, s3, rx_level, rx_prev;
  rx_state_t   rx_st;
  logic [3:0]  os_cnt, bit_idx, tx_os, tx_bits;
  logic [1:0]  smp;
  logic [8:0]  receive_shift_register;
  logic        tick, noise_acc, maj, dis, at_mid, push, brk_armed, receiver_idle_flag;
  logic [11:0] push_data, head;
  logic        fifo_full, fifo_empty, overrun_flag, armed, pop, bus_req, rd_status, rd_data;
  word_t       next_dat;
  tx_state_t   tx_st;
  logic [8:0]  brk_cnt;
  logic        receiver_enable, nine_bit_select, parity_enable, parity_type;
  logic        two_stop, break_request, receive_interrupt_enable;

  assign receiver_enable          = serial_control_one[`CB_RECEIVER_ENABLE];
  assign nine_bit_select          = serial_control_one[`CB_NINE];
  assign parity_enable            = serial_control_one[`CB_PEN];
  assign parity_type              = serial_control_one[`CB_PTYPE];
  assign two_stop                 = serial_control_one[`CB_TWOSTOP];
  assign break_request            = serial_control_one[`CB_BRK];
  assign receive_interrupt_enable = serial_control_one[`CB_RIE];

  // Bus decode; the answer comes one cycle after the request and lasts one cycle.
  assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign rd_status = bus_req & ~wb_we_i & (wb_adr_i == `OFS_STATUS);
  assign rd_data   = bus_req & ~wb_we_i & (wb_adr_i == `OFS_DATA);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Control and divisor writes; only byte lane zero carries fields.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_control_one <= `CTRL_RST;
      baud_divisor       <= `BAUD_RST;
    end else if (bus_req && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == `OFS_CTRL) begin
        serial_control_one <= wb_dat_i[6:0];
      end
      if (wb_adr_i == `OFS_BAUD) begin
        baud_divisor <= wb_dat_i[7:0];
      end
    end
  end

  // Read mux; unmapped addresses and writes answer with zero.
  always_comb begin
    next_dat = 32'h0000_0000;
    if (bus_req && !wb_we_i) begin
      unique case (wb_adr_i)
        `OFS_CTRL:   next_dat[6:0] = serial_control_one;
        `OFS_BAUD:   next_dat[7:0] = baud_divisor;
        `OFS_DATA:   next_dat[8:0] = head[8:0];
        `OFS_STATUS: next_dat[5:0] = {receiver_idle_flag, head[9], head[10],
                                      head[11] & ~fifo_empty, overrun_flag, ~fifo_empty};
        default:     next_dat = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_dat_o <= next_dat;
    end
  end

  // Read sequence: a status read arms, the following data read pops.
  assign pop = rd_data & armed;

  always_ff @(posedge clk_i) begin
    if (rst_i || !receiver_enable) begin
      armed <= 1'b0;
    end else if (rd_status) begin
      armed <= 1'b1;
    end else if (rd_data) begin
      armed <= 1'b0;
    end
  end

  // Sixteen-times baud tick from the divisor.
  always_ff @(posedge clk_i) begin
    if (rst_i || div_cnt == baud_divisor) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end
  assign tick = (div_cnt == baud_divisor);

  // Pin synchroniser; the level changes only when the last two stages agree.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1       <= 1'b1;
      s2       <= 1'b1;
      s3       <= 1'b1;
      rx_level <= 1'b1;
      rx_prev  <= 1'b1;
    end else begin
      s1      <= rx_i;
      s2      <= s1;
      s3      <= s2;
      rx_prev <= rx_level;
      if (s2 == s3) begin
        rx_level <= s3;
      end
    end
  end

  // Majority of the samples taken at ticks seven, eight and nine.
  assign maj    = (smp[0] & smp[1]) | (smp[0] & rx_level) | (smp[1] & rx_level);
  assign dis    = ~((smp[0] == smp[1]) && (smp[1] == rx_level));
  assign at_mid = tick && os_cnt == `SMP_C;

  // Hand the word over at the stop sample; the buffer refuses it if full, unless a pop comes in the same cycle.
  assign push = (rx_st == R_STOP) && at_mid;
  // Stop sampled low is a framing error; parity over all frame bits.
  assign push_data = {noise_acc | dis, ~maj,
                      parity_enable & ((^receive_shift_register) != parity_type),
                      receive_shift_register};

  // Receive state machine.
  always_ff @(posedge clk_i) begin
    if (rst_i || !receiver_enable) begin
      rx_st   <= R_IDLE;
      os_cnt  <= 4'h0;
      bit_idx <= 4'h0;
      smp     <= 2'b11;
      noise_acc <= 1'b0;
      receive_shift_register <= 9'h000;
    end else begin
      if (tick) begin
        os_cnt <= os_cnt + 4'h1;
        if (os_cnt == `SMP_A) smp[0] <= rx_level;
        if (os_cnt == `SMP_B) smp[1] <= rx_level;
        if (at_mid && rx_st != R_IDLE) noise_acc <= noise_acc | dis;
      end
      unique case (rx_st)
        R_IDLE: begin
          if (rx_prev && !rx_level) begin
            rx_st     <= R_START;
            os_cnt    <= 4'h0;
            noise_acc <= 1'b0;
            receive_shift_register <= 9'h000;
          end
        end
        R_START: begin
          // A start bit not low at mid-bit was a glitch.
          if (at_mid && maj) begin
            rx_st <= R_IDLE;
          end else if (tick && os_cnt == `OS_LAST) begin
            rx_st   <= R_DATA;
            bit_idx <= 4'h0;
          end
        end
        R_DATA: begin
          if (at_mid) begin
            receive_shift_register[bit_idx] <= maj;
          end
          // Eight or nine frame bits; one stop bit checked.
          if (tick && os_cnt == `OS_LAST) begin
            if (bit_idx == (nine_bit_select ? 4'h8 : 4'h7)) begin
              rx_st <= R_STOP;
            end
            bit_idx <= bit_idx + 4'h1;
          end
        end
        R_STOP: begin
          // A break ends here after word plus one stop, then waits.
          if (at_mid) begin
            rx_st <= maj ? R_IDLE : R_WAIT;
          end
        end
        R_WAIT: begin
          // A line still low after a break is not a start bit.
          if (rx_level) begin
            rx_st <= R_IDLE;
          end
        end
        default: rx_st <= R_IDLE;
      endcase
    end
  end

  // Idle from the stop sample until the next start detection.
  assign receiver_idle_flag = (rx_st == R_IDLE) || (rx_st == R_WAIT);

  // Two-entry buffer; flags travel with the word.
  rx_fifo #(.WIDTH(12), .DEPTH(2)) u_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .flush_i     (~receiver_enable),
    .push_i      (push),
    .push_data_i (push_data),
    .pop_i       (pop),
    .full_o      (fifo_full),
    .empty_o     (fifo_empty),
    .head_o      (head)
  );

  // Overrun is sticky; the clearing read wins over a new overrun.
  always_ff @(posedge clk_i) begin
    if (rst_i || !receiver_enable) begin
      overrun_flag <= 1'b0;
    end else begin
      overrun_flag <= (push & fifo_full & ~pop) | (overrun_flag & ~pop);
    end
  end

  // Transfer or overrun pulses the request; noise adds none.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_int_req_o <= 1'b0;
    end else begin
      rx_int_req_o <= push & receive_interrupt_enable;
    end
  end

  // The request must stand beyond divisor plus one clocks to arm.
  always_ff @(posedge clk_i) begin
    if (rst_i || !break_request) begin
      brk_cnt   <= 9'h000;
      brk_armed <= 1'b0;
    end else if (brk_cnt > {1'b0, baud_divisor}) begin
      brk_armed <= 1'b1;
    end else begin
      brk_cnt <= brk_cnt + 9'h001;
    end
  end

  // Break sender; bit periods are sixteen ticks. No transmit flag exists.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_st   <= T_IDLE;
      tx_os   <= 4'h0;
      tx_bits <= 4'h0;
    end else begin
      if (tick) begin
        tx_os <= tx_os + 4'h1;
      end
      unique case (tx_st)
        T_IDLE: begin
          if (brk_armed && tick) begin // Start on a tick so the first bit is full length.
            tx_st   <= T_BRK;
            tx_os   <= 4'h0;
            tx_bits <= 4'h0;
          end
        end
        T_BRK: begin
          // Start bit then thirteen zeros; each repeated break adds thirteen zeros.
          if (tick && tx_os == `OS_LAST) begin
            if (tx_bits == `BRK_BITS) begin
              // Repeat while requested, else go to stop bits.
              tx_st   <= break_request ? T_BRK : T_STOP;
              tx_bits <= break_request ? 4'h1 : 4'h0;
            end else begin
              tx_bits <= tx_bits + 4'h1;
            end
          end
        end
        T_STOP: begin
          if (tick && tx_os == `OS_LAST) begin
            tx_bits <= tx_bits + 4'h1;
            if (tx_bits == {3'b000, two_stop}) begin
              tx_st <= T_IDLE;
            end
          end
        end
        default: tx_st <= T_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_o <= 1'b1;
    end else begin
      tx_o <= (tx_st != T_BRK);
    end
  end

  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held more than one cycle");
  ack_timing_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  brk_arm_a: assert property (@(posedge clk_i) disable iff (rst_i)
    brk_armed |-> brk_cnt == {1'b0, baud_divisor} + 9'h001)
    else $error("break armed at wrong count");
  brk_line_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_st == T_BRK |=> !tx_o)
    else $error("line high during break");
  brk_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_st == T_BRK ##1 tx_st == T_STOP |-> $past(tx_bits) == `BRK_BITS)
    else $error("break shorter than thirteen bits");
  idle_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_st == R_DATA |-> !receiver_idle_flag)
    else $error("idle flag high inside frame");
  overrun_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    push && fifo_full && !pop && receiver_enable |=> overrun_flag && fifo_full)
    else $error("overrun not flagged");
  ready_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    push && receive_interrupt_enable |=> rx_int_req_o)
    else $error("receive request missing");
  break_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_st == R_WAIT && !rx_level && receiver_enable |=> rx_st == R_WAIT)
    else $error("left break wait on low line");
endmodule : uart_rx_break

// ==== bench/serial_station.sv ====
// Remote serial station model: drives the receive line and times transmit low runs.
`timescale 1ns/1ps
module serial_station #(
  parameter int BIT_CLKS = 64
) (
  input  wire logic clk_i,
  input  wire logic tx_i,
  output logic      line_o
);
  int run      = 0;
  int low_len  = 0;
  int low_runs = 0;

  initial line_o = 1'b1;

  // Holds one level for some clocks; a four-clock flip always hits exactly one of three samples.
  task automatic hold(input logic lvl, input int clks, input bit glitch);
    for (int i = 0; i < clks; i++) begin
      line_o <= (glitch && i >= 35 && i < 39) ? ~lvl : lvl;
      @(posedge clk_i);
    end
  endtask : hold

  // Start bit, bits least significant first, an optional low stop, then idle high.
  task automatic send(input logic [8:0] v, input int nb, input int stop_low, input bit glitch);
    hold(1'b0, BIT_CLKS, 1'b0);
    for (int b = 0; b < nb; b++) hold(v[b], BIT_CLKS, glitch && b == 0);
    hold(1'b0, stop_low * BIT_CLKS, 1'b0);
    hold(1'b1, 2 * BIT_CLKS, 1'b0);
  endtask : send

  // Long low line, as a remote break, then a valid high level.
  task automatic send_low(input int nbits);
    hold(1'b0, nbits * BIT_CLKS, 1'b0);
    hold(1'b1, 2 * BIT_CLKS, 1'b0);
  endtask : send_low

  // Break run length, counted in clocks of low line.
  always @(posedge clk_i) begin
    if (tx_i === 1'b0) begin
      run <= run + 1;
    end else begin
      if (run > 0) begin
        low_len  <= run;
        low_runs <= low_runs + 1;
      end
      run <= 0;
    end
  end
endmodule : serial_station

// ==== bench/test_uart_rx_break.sv ====
// Self-checking bench for the serial receiver and break sender.
`timescale 1ns/1ps
`include "uart_rx_consts.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module test_uart_rx_break;
  import uart_rx_pkg::*;
  localparam int DIV  = 3;
  localparam int BITC = 16 * (DIV + 1);
  logic        clk_i, rst_i, cyc, stb, we, ack, rx, tx, irq;
  logic [3:0]  adr;
  word_t       dat_w, dat_r, got, want;
  word_t       exp_q[$];
  word_t       msk_q[$];
  int          err_count, total_checks, irq_count, irq_exp, runs;
  logic [31:0] lfsr;
  logic [8:0]  d, e2, e3;

  uart_rx_break i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat_w), .wb_dat_o(dat_r),
    .wb_ack_o(ack), .rx_i(rx), .tx_o(tx), .rx_int_req_o(irq));
  serial_station #(.BIT_CLKS(BITC)) i_peer (.clk_i(clk_i), .tx_i(tx), .line_o(rx));

  // Free-running 200 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Compares each read answer with the oldest note and counts request pulses.
  always @(posedge clk_i) begin
    if (irq === 1'b1) irq_count++;
    if (ack === 1'b1 && we === 1'b0) begin
      got  = dat_r & msk_q.pop_front();
      want = exp_q.pop_front();
      `CHK(got, want)
    end
  end

  function automatic logic [8:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[8:0];
  endfunction : rnd

  task automatic print_verdict();
    if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // One classic cycle held until ack is sampled, then released for a cycle.
  task automatic wb(input logic w, input logic [3:0] a, input word_t v);
    int n;
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    dat_w <= v;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    if (n == 50) begin
      err_count++;
      print_verdict();
    end
  endtask : wb

  task automatic rd(input logic [3:0] a, input word_t v, input word_t m);
    exp_q.push_back(v);
    msk_q.push_back(m);
    wb(1'b0, a, '0);
  endtask : rd

  task automatic take(input word_t st, input word_t v);
    rd(`OFS_STATUS, st, 32'h3F);
    rd(`OFS_DATA, v, 32'h1FF);
  endtask : take

  task automatic frame(input logic [8:0] v, input int nb, input int sl, input bit g);
    i_peer.send(v, nb, sl, g);
    irq_exp++;
  endtask : frame

  initial begin
    rst_i = 1'b1;
    cyc   = 1'b0;
    stb   = 1'b0;
    we    = 1'b0;
    adr   = 4'h0;
    dat_w = '0;
    lfsr  = 32'h19F5173E;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(`OFS_CTRL, 32'h0, '1);
    rd(`OFS_BAUD, 32'h0, '1);
    rd(`OFS_STATUS, 32'h20, '1);
    wb(1'b1, 4'h2, 32'hFF);
    rd(4'h2, 32'h0, '1);
    wb(1'b1, `OFS_BAUD, DIV);
    rd(`OFS_BAUD, DIV, '1);
    wb(1'b1, `OFS_CTRL, 32'h41);
    for (int i = 0; i < 3; i++) begin
      d = rnd() & 9'h0FF;
      fork
        frame(d, 8, 0, 1'b0);
        begin
          repeat (3 * BITC) @(posedge clk_i);
          rd(`OFS_STATUS, 32'h0, 32'h20);
        end
      join
      take(32'h21, d);
      rd(`OFS_STATUS, 32'h20, 32'h27);
    end
    // Nine-bit words: two held, the third overruns.
    wb(1'b1, `OFS_CTRL, 32'h43);
    d  = rnd();
    e2 = rnd();
    e3 = rnd();
    frame(d, 9, 0, 1'b0);
    frame(e2, 9, 0, 1'b0);
    frame(e3, 9, 0, 1'b0);
    rd(`OFS_STATUS, 32'h23, 32'h27);
    rd(`OFS_DATA, d, 32'h1FF);
    rd(`OFS_DATA, e2, 32'h1FF);
    rd(`OFS_DATA, e2, 32'h1FF);
    take(32'h21, e2);
    rd(`OFS_STATUS, 32'h20, 32'h27);
    // Parity of both types, good and bad.
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, `OFS_CTRL, 32'h45 | (i[0] << 3));
      d    = rnd() & 9'h07F;
      d[7] = ^d[6:0] ^ i[0] ^ i[1];
      frame(d, 8, 0, 1'b0);
      take(32'h21 | (i[1] << 4), d);
    end
    wb(1'b1, `OFS_CTRL, 32'h41);
    d = rnd() & 9'h0FF;
    frame(d, 8, 0, 1'b1);
    take(32'h25, d);
    d = rnd() & 9'h0FF;
    frame(d, 8, 1, 1'b0);
    take(32'h29, d);
    fork
      i_peer.send_low(20);
      begin
        repeat (15 * BITC) @(posedge clk_i);
        take(32'h29, 32'h0);
      end
    join
    irq_exp++;
    d = rnd() & 9'h0FF;
    frame(d, 8, 0, 1'b0);
    take(32'h21, d);
    `CHK(irq_count, irq_exp)
    // A request shorter than the arming time sends nothing.
    runs = i_peer.low_runs;
    wb(1'b1, `OFS_CTRL, 32'h61);
    wb(1'b1, `OFS_CTRL, 32'h41);
    repeat (20 * BITC) @(posedge clk_i);
    `CHK(i_peer.low_runs, runs)
    // Long request with two stop bits selected: three break blocks, then stop.
    wb(1'b1, `OFS_CTRL, 32'h71);
    repeat (30 * BITC) @(posedge clk_i);
    wb(1'b1, `OFS_CTRL, 32'h51);
    repeat (20 * BITC) @(posedge clk_i);
    `CHK(i_peer.low_runs, runs + 1)
    `CHK(i_peer.low_len, 40 * BITC)
    `CHK(tx, 1'b1)
    `CHK(irq_count, irq_exp)
    print_verdict();
  end
endmodule : test_uart_rx_break
